// ### src/dam_pkg.sv
// Shared constants and types of the digital audio mixer
package dam_pkg;
	localparam int SAMPLE_W = 24;
	localparam logic signed [SAMPLE_W-1:0] SAMPLE_MAX = 24'sh7fffff;
	localparam logic signed [SAMPLE_W-1:0] SAMPLE_MIN = 24'sh800000;
	// Register indexes; byte address is four times the index
	localparam logic [5:0] IDX_IFACE_ROUTING = 6'h18;
	localparam logic [5:0] IDX_DAC_SIDETONE = 6'h20;
	localparam logic [5:0] IDX_MIC_POLARITY = 6'h26;
	localparam logic [5:0] IDX_MIX_STATUS = 6'h27;
	// audio_iface_routing_ctrl fields
	localparam int DAC_L_INV_BIT = 12;
	localparam int DAC_R_INV_BIT = 11;
	localparam int BOOST_LSB = 9;
	localparam int TX_L_SRC_BIT = 7;
	localparam int TX_R_SRC_BIT = 6;
	localparam int DAC_L_SRC_BIT = 5;
	localparam int DAC_R_SRC_BIT = 4;
	localparam logic [15:0] ROUTING_RST = 16'h0050;
	localparam logic [15:0] ROUTING_MASK = 16'h1ef0;
	// dac_sidetone_ctrl fields
	localparam int ST_L_ATTEN_LSB = 8;
	localparam int ST_R_ATTEN_LSB = 4;
	localparam int ST_L_SRC_LSB = 2;
	localparam int ST_R_SRC_LSB = 0;
	localparam logic [15:0] SIDETONE_RST = 16'h0000;
	localparam logic [15:0] SIDETONE_MASK = 16'h0fff;
	localparam logic [1:0] ST_SRC_NONE = 2'h0;
	localparam logic [1:0] ST_SRC_LEFT = 2'h1;
	localparam logic [1:0] ST_SRC_RIGHT = 2'h2;
	// mic_polarity_ctrl fields
	localparam int MIC_L_INV_BIT = 1;
	localparam int MIC_R_INV_BIT = 0;
	localparam logic [15:0] POLARITY_RST = 16'h0000;
	localparam logic [15:0] POLARITY_MASK = 16'h0003;
	// Sidetone gain: code 12 and up is unity, 3dB per code below
	localparam logic [3:0] ST_UNITY_CODE = 4'hc;
	localparam logic signed [8:0] ST_HALF_STEP_MULT = 9'sh0b5;
	localparam int ST_MULT_SHIFT = 8;

	typedef struct packed {
		logic [15:0] routing;
		logic [15:0] sidetone;
		logic [15:0] polarity;
		logic [1:0] sat_flag;
		logic ack;
		logic [31:0] rdat;
		logic signed [SAMPLE_W-1:0] tx_l;
		logic signed [SAMPLE_W-1:0] tx_r;
		logic tx_v;
		logic signed [SAMPLE_W-1:0] st_l;
		logic signed [SAMPLE_W-1:0] st_r;
		logic signed [SAMPLE_W-1:0] dac_l;
		logic signed [SAMPLE_W-1:0] dac_r;
		logic dac_v;
	} dam_state_t;
endpackage : dam_pkg

// ### src/dam_st_if.sv
// Carrier between the mixer and one sidetone gain stage
`timescale 1ns/100ps
`default_nettype none
interface dam_st_if
	import dam_pkg::*;
	();
	logic signed [SAMPLE_W-1:0] sample;
	logic [3:0] code;
	logic signed [SAMPLE_W-1:0] gain;
	modport user (output sample, output code, input gain);
	modport stage (input sample, input code, output gain);
endinterface : dam_st_if
`default_nettype wire

// ### src/dam_st_gain.sv
// Sidetone attenuator: -36dB to 0dB in 3dB steps
`timescale 1ns/100ps
`default_nettype none
module dam_st_gain
	import dam_pkg::*;
	(
	dam_st_if.stage port
);
	logic [3:0] steps;
	logic [2:0] shift;
	logic signed [SAMPLE_W-1:0] shifted;
	logic signed [SAMPLE_W+8:0] prod;

	// Codes above unity saturate at 0dB
	assign steps = (port.code >= ST_UNITY_CODE) ? 4'h0 : ST_UNITY_CODE - port.code;
	// Each pair of steps is one 6dB shift, the odd step is x181/256
	assign shift = steps[3:1];
	assign shifted = port.sample >>> shift;
	assign prod = shifted * ST_HALF_STEP_MULT;
	assign port.gain = steps[0] ? prod[SAMPLE_W+ST_MULT_SHIFT-1:ST_MULT_SHIFT] : shifted;
endmodule : dam_st_gain
`default_nettype wire

// ### src/dam_mixer.sv
// Digital audio mixer core with Wishbone register slave
//
// Added by the designer: the Wishbone register port.
`timescale 1ns/100ps
`default_nettype none
module dam_mixer
	import dam_pkg::*;
	(
	input wire logic mclk_i,
	input wire logic arst_n_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	input wire logic mic_valid_i,
	input wire logic signed [SAMPLE_W-1:0] mic_left_i,
	input wire logic signed [SAMPLE_W-1:0] mic_right_i,
	input wire logic signed [SAMPLE_W-1:0] mic_hpf_left_i,
	input wire logic signed [SAMPLE_W-1:0] mic_hpf_right_i,
	input wire logic rx_valid_i,
	input wire logic signed [SAMPLE_W-1:0] rx_left_i,
	input wire logic signed [SAMPLE_W-1:0] rx_right_i,
	output logic tx_valid_o,
	output logic signed [SAMPLE_W-1:0] tx_left_o,
	output logic signed [SAMPLE_W-1:0] tx_right_o,
	output logic dac_valid_o,
	output logic signed [SAMPLE_W-1:0] dac_left_o,
	output logic signed [SAMPLE_W-1:0] dac_right_o
);
	dam_state_t r;
	dam_state_t next_r;
	logic signed [SAMPLE_W-1:0] st_gain [2];
	logic [1:0] st_src [2];

	// Negating full negative scale would wrap, so clamp it
	function automatic logic signed [SAMPLE_W-1:0] neg_sat(input logic signed [SAMPLE_W-1:0] x);
		if (x == SAMPLE_MIN) begin
			return SAMPLE_MAX;
		end
		return -x;
	endfunction : neg_sat

	function automatic logic signed [SAMPLE_W-1:0] clip(input logic signed [SAMPLE_W+3:0] v);
		if ((&v[SAMPLE_W+3:SAMPLE_W-1]) || !(|v[SAMPLE_W+3:SAMPLE_W-1])) begin
			return v[SAMPLE_W-1:0];
		end
		return v[SAMPLE_W+3] ? SAMPLE_MIN : SAMPLE_MAX;
	endfunction : clip

	function automatic logic sum_over(input logic signed [SAMPLE_W+3:0] v);
		return !((&v[SAMPLE_W+3:SAMPLE_W-1]) || !(|v[SAMPLE_W+3:SAMPLE_W-1]));
	endfunction : sum_over

	assign st_src[0] = r.sidetone[ST_L_SRC_LSB +: 2];
	assign st_src[1] = r.sidetone[ST_R_SRC_LSB +: 2];

	// One sidetone stage per DAC channel
	dam_st_if st_bus [2] ();
	genvar gi;
	generate
		for (gi = 0; gi < 2; gi++) begin : g_st
			// Reserved source code 11 mixes nothing
			assign st_bus[gi].sample = (st_src[gi] == ST_SRC_LEFT) ? r.st_l :
				(st_src[gi] == ST_SRC_RIGHT) ? r.st_r : '0;
			assign st_bus[gi].code = (gi == 0) ? r.sidetone[ST_L_ATTEN_LSB +: 4] :
				r.sidetone[ST_R_ATTEN_LSB +: 4];
			dam_st_gain u_gain (
				.port(st_bus[gi])
			);
			assign st_gain[gi] = st_bus[gi].gain;
		end
	endgenerate

	always_comb begin
		logic [5:0] idx;
		logic [15:0] wmask;
		logic signed [SAMPLE_W-1:0] mic_l;
		logic signed [SAMPLE_W-1:0] mic_r;
		logic signed [SAMPLE_W-1:0] rx_sel [2];
		logic signed [SAMPLE_W+3:0] boosted [2];
		logic signed [SAMPLE_W+3:0] sum [2];
		logic [1:0] sat_set;
		logic [1:0] sat_clr;
		idx = wb_adr_i[7:2];
		wmask = {{8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
		mic_l = '0;
		mic_r = '0;
		rx_sel[0] = '0;
		rx_sel[1] = '0;
		boosted[0] = '0;
		boosted[1] = '0;
		sum[0] = '0;
		sum[1] = '0;
		sat_set = 2'h0;
		sat_clr = 2'h0;
		next_r = r;

		// Classic slave: answer one cycle after the strobe, drop after one
		next_r.ack = wb_cyc_i && wb_stb_i && !r.ack;
		next_r.rdat = 32'h0;
		if (wb_cyc_i && wb_stb_i && !r.ack) begin
			case (idx)
				IDX_IFACE_ROUTING: begin
					next_r.rdat = {16'h0, r.routing & ROUTING_MASK};
					if (wb_we_i) begin
						next_r.routing = (r.routing & ~(wmask & ROUTING_MASK)) |
							(wb_dat_i[15:0] & wmask & ROUTING_MASK);
					end
				end
				IDX_DAC_SIDETONE: begin
					next_r.rdat = {16'h0, r.sidetone & SIDETONE_MASK};
					if (wb_we_i) begin
						next_r.sidetone = (r.sidetone & ~(wmask & SIDETONE_MASK)) |
							(wb_dat_i[15:0] & wmask & SIDETONE_MASK);
					end
				end
				IDX_MIC_POLARITY: begin
					next_r.rdat = {16'h0, r.polarity & POLARITY_MASK};
					if (wb_we_i) begin
						next_r.polarity = (r.polarity & ~(wmask & POLARITY_MASK)) |
							(wb_dat_i[15:0] & wmask & POLARITY_MASK);
					end
				end
				IDX_MIX_STATUS: begin
					next_r.rdat = {30'h0, r.sat_flag};
					if (wb_we_i && wb_sel_i[0]) begin
						sat_clr = wb_dat_i[1:0];
					end
				end
				default: begin
					next_r.rdat = 32'h0;
				end
			endcase
		end

		// Microphone side: polarity first, then slot routing
		mic_l = r.polarity[MIC_L_INV_BIT] ? neg_sat(mic_left_i) : mic_left_i;
		mic_r = r.polarity[MIC_R_INV_BIT] ? neg_sat(mic_right_i) : mic_right_i;
		next_r.tx_v = mic_valid_i;
		if (mic_valid_i) begin
			next_r.tx_l = r.routing[TX_L_SRC_BIT] ? mic_r : mic_l;
			next_r.tx_r = r.routing[TX_R_SRC_BIT] ? mic_r : mic_l;
			// Sidetone holds the filtered sample, not the raw one
			next_r.st_l = r.polarity[MIC_L_INV_BIT] ? neg_sat(mic_hpf_left_i) :
				mic_hpf_left_i;
			next_r.st_r = r.polarity[MIC_R_INV_BIT] ? neg_sat(mic_hpf_right_i) :
				mic_hpf_right_i;
		end

		// Receive side: source, invert, boost, then sidetone sum
		rx_sel[0] = r.routing[DAC_L_SRC_BIT] ? rx_right_i : rx_left_i;
		rx_sel[1] = r.routing[DAC_R_SRC_BIT] ? rx_right_i : rx_left_i;
		if (r.routing[DAC_L_INV_BIT]) begin
			rx_sel[0] = neg_sat(rx_sel[0]);
		end
		if (r.routing[DAC_R_INV_BIT]) begin
			rx_sel[1] = neg_sat(rx_sel[1]);
		end
		for (int ch = 0; ch < 2; ch++) begin
			boosted[ch] = {{4{rx_sel[ch][SAMPLE_W-1]}}, rx_sel[ch]} <<<
				r.routing[BOOST_LSB +: 2];
			sum[ch] = boosted[ch] + {{4{st_gain[ch][SAMPLE_W-1]}}, st_gain[ch]};
		end
		next_r.dac_v = rx_valid_i;
		if (rx_valid_i) begin
			next_r.dac_l = clip(sum[0]);
			next_r.dac_r = clip(sum[1]);
			sat_set = {sum_over(sum[1]), sum_over(sum[0])};
		end
		// A clip in the same cycle as a clear is kept
		next_r.sat_flag = (r.sat_flag & ~sat_clr) | sat_set;
	end

	always_ff @(posedge mclk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			r <= '0;
			r.routing <= ROUTING_RST;
			r.sidetone <= SIDETONE_RST;
			r.polarity <= POLARITY_RST;
		end else begin
			r <= next_r;
		end
	end

	assign wb_dat_o = r.rdat;
	assign wb_ack_o = r.ack;
	assign tx_valid_o = r.tx_v;
	assign tx_left_o = r.tx_l;
	assign tx_right_o = r.tx_r;
	assign dac_valid_o = r.dac_v;
	assign dac_left_o = r.dac_l;
	assign dac_right_o = r.dac_r;

	// Checks on the mixing paths and the bus answer
	default clocking cb @(posedge mclk_i);
	endclocking
	default disable iff (!arst_n_i);

	logic plain_rx_l;
	logic plain_rx_r;
	assign plain_rx_l = r.routing[BOOST_LSB +: 2] == 2'h0 && st_src[0] == ST_SRC_NONE &&
		!r.routing[DAC_L_INV_BIT];
	assign plain_rx_r = r.routing[BOOST_LSB +: 2] == 2'h0 && st_src[1] == ST_SRC_NONE &&
		!r.routing[DAC_R_INV_BIT];

	sequence s_wb_req;
		wb_cyc_i && wb_stb_i && !wb_ack_o;
	endsequence

	sequence s_wb_answer;
		wb_ack_o ##1 !wb_ack_o;
	endsequence

	sequence s_mic_left_plain;
		mic_valid_i && !r.routing[TX_L_SRC_BIT] && !r.polarity[MIC_L_INV_BIT];
	endsequence

	a_wb_answer: assert property (s_wb_req |=> s_wb_answer)
		else $error("bus request not answered in one cycle");

	a_txl_route: assert property (s_mic_left_plain |=> tx_valid_o &&
		tx_left_o == $past(mic_left_i))
		else $error("left transmit slot not fed from left mic");

	a_txr_route: assert property (mic_valid_i && r.routing[TX_R_SRC_BIT] &&
		!r.polarity[MIC_R_INV_BIT] |=> tx_right_o == $past(mic_right_i))
		else $error("right transmit slot not fed from right mic");

	a_mic_invert: assert property (mic_valid_i && !r.routing[TX_L_SRC_BIT] &&
		r.polarity[MIC_L_INV_BIT] && mic_left_i != SAMPLE_MIN
		|=> tx_left_o == -$past(mic_left_i))
		else $error("left mic polarity not inverted");

	a_dacl_route: assert property (rx_valid_i && plain_rx_l && !r.routing[DAC_L_SRC_BIT]
		|=> dac_valid_o && dac_left_o == $past(rx_left_i))
		else $error("left DAC not fed from left receive channel");

	a_dacr_route: assert property (rx_valid_i && plain_rx_r && r.routing[DAC_R_SRC_BIT]
		|=> dac_right_o == $past(rx_right_i))
		else $error("right DAC not fed from right receive channel");

	a_dac_invert: assert property (rx_valid_i && r.routing[BOOST_LSB +: 2] == 2'h0 &&
		st_src[0] == ST_SRC_NONE && r.routing[DAC_L_INV_BIT] &&
		!r.routing[DAC_L_SRC_BIT] && rx_left_i != SAMPLE_MIN
		|=> dac_left_o == -$past(rx_left_i))
		else $error("left DAC polarity not inverted");

	a_boost_six: assert property (rx_valid_i && r.routing[BOOST_LSB +: 2] == 2'h1 &&
		st_src[0] == ST_SRC_NONE && !r.routing[DAC_L_INV_BIT] &&
		!r.routing[DAC_L_SRC_BIT] && rx_left_i[SAMPLE_W-1] == rx_left_i[SAMPLE_W-2]
		|=> dac_left_o == {$past(rx_left_i[SAMPLE_W-2:0]), 1'b0})
		else $error("6dB boost not a doubling");

	a_sum_clip: assert property (rx_valid_i && r.routing[BOOST_LSB +: 2] == 2'h3 &&
		st_src[0] == ST_SRC_NONE && !r.routing[DAC_L_INV_BIT] &&
		!r.routing[DAC_L_SRC_BIT] && rx_left_i == SAMPLE_MAX
		|=> dac_left_o == SAMPLE_MAX && r.sat_flag[0])
		else $error("overflowing DAC sum not clamped");

	a_st_unity: assert property (rx_valid_i && rx_left_i == '0 && !r.routing[DAC_L_SRC_BIT] &&
		st_src[0] == ST_SRC_LEFT && r.sidetone[ST_L_ATTEN_LSB +: 4] >= ST_UNITY_CODE
		|=> dac_left_o == $past(r.st_l))
		else $error("unity sidetone not added to left DAC");
endmodule : dam_mixer
`default_nettype wire

// ### bench/dam_far_model.sv
// Far-side model: mic filters and received interface samples
`timescale 1ns/100ps
`default_nettype none
module dam_far_model
	import dam_pkg::*;
	(
	input wire logic mclk_i,
	output logic mic_valid_o,
	output logic signed [SAMPLE_W-1:0] mic_l_o,
	output logic signed [SAMPLE_W-1:0] mic_r_o,
	output logic signed [SAMPLE_W-1:0] hpf_l_o,
	output logic signed [SAMPLE_W-1:0] hpf_r_o,
	output logic rx_valid_o,
	output logic signed [SAMPLE_W-1:0] rx_l_o,
	output logic signed [SAMPLE_W-1:0] rx_r_o
);
	initial begin
		{mic_valid_o, mic_l_o, mic_r_o, hpf_l_o, hpf_r_o} = '0;
		{rx_valid_o, rx_l_o, rx_r_o} = '0;
	end
	// Lines go inverse after the strobe, so a design that misses its latch shows it
	task send_mic(input logic signed [SAMPLE_W-1:0] l, r, hl, hr);
		@(posedge mclk_i);
		mic_valid_o <= 1'b1;
		{mic_l_o, mic_r_o, hpf_l_o, hpf_r_o} <= {l, r, hl, hr};
		@(posedge mclk_i);
		mic_valid_o <= 1'b0;
		{mic_l_o, mic_r_o, hpf_l_o, hpf_r_o} <= ~{l, r, hl, hr};
	endtask : send_mic
	task send_rx(input logic signed [SAMPLE_W-1:0] l, r);
		@(posedge mclk_i);
		rx_valid_o <= 1'b1;
		{rx_l_o, rx_r_o} <= {l, r};
		@(posedge mclk_i);
		rx_valid_o <= 1'b0;
		{rx_l_o, rx_r_o} <= ~{l, r};
	endtask : send_rx
endmodule : dam_far_model
`default_nettype wire

// ### bench/dam_mixer_tb.sv
// Self-checking bench of the digital audio mixer
`timescale 1ns/100ps
`default_nettype none
module dam_mixer_tb
	import dam_pkg::*;
	;
	logic mclk_i = 1'b0;
	logic arst_n_i = 1'b0;
	logic cyc = 1'b0, stb = 1'b0, we = 1'b0;
	logic [7:0] adr = 8'h00;
	logic [31:0] dat = 32'h0, rdat;
	logic ack, mic_v, rx_v, tx_v, dac_v;
	logic signed [SAMPLE_W-1:0] ml, mr, hl, hr, rl, rr, txl, txr, dl, dr;
	int n_fail = 0, checked = 0;
	always #2 mclk_i = ~mclk_i;
	dam_far_model i_far (.mclk_i(mclk_i), .mic_valid_o(mic_v), .mic_l_o(ml), .mic_r_o(mr),
		.hpf_l_o(hl), .hpf_r_o(hr), .rx_valid_o(rx_v), .rx_l_o(rl), .rx_r_o(rr));
	dam_mixer i_dut (.mclk_i(mclk_i), .arst_n_i(arst_n_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
		.wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'h3), .wb_dat_i(dat), .wb_dat_o(rdat),
		.wb_ack_o(ack), .mic_valid_i(mic_v), .mic_left_i(ml), .mic_right_i(mr),
		.mic_hpf_left_i(hl), .mic_hpf_right_i(hr), .rx_valid_i(rx_v), .rx_left_i(rl),
		.rx_right_i(rr), .tx_valid_o(tx_v), .tx_left_o(txl), .tx_right_o(txr),
		.dac_valid_o(dac_v), .dac_left_o(dl), .dac_right_o(dr));
	task tally_and_finish;
		$display("checked %0d, n_fail %0d", checked, n_fail);
		if (n_fail == 0 && checked > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask : tally_and_finish
	task chk(input logic [23:0] seen, exp);
		checked++;
		if (seen !== exp) begin
			n_fail++;
			$display("wrong value at %0t: saw %h, expected %h", $time, seen, exp);
		end
	endtask : chk
	// Ack and data are read as they stood at the edge, before its updates land
	task wb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
		int n;
		n = 0;
		@(posedge mclk_i);
		{cyc, stb, we, adr, dat} <= {1'b1, 1'b1, w, a, d};
		do begin
			@(posedge mclk_i);
			n++;
		end while (ack !== 1'b1 && n < 64);
		if (ack !== 1'b1) begin
			n_fail++;
			tally_and_finish();
		end
		q = rdat;
		{cyc, stb, we} <= 3'b000;
	endtask : wb
	task wr(input logic [7:0] a, input logic [15:0] d);
		logic [31:0] q;
		wb(1'b1, a, {16'h0, d}, q);
	endtask : wr
	task rdc(input logic [7:0] a, input logic [23:0] e);
		logic [31:0] q;
		wb(1'b0, a, 32'h0, q);
		chk(q[23:0], e);
	endtask : rdc
	function automatic longint neg(longint x);
		return (x == -8388608) ? 8388607 : -x;
	endfunction : neg
	function automatic longint gain(longint x, logic [3:0] c);
		int s;
		s = (c > 4'hc) ? 0 : 12 - c;
		x = x >>> (s / 2);
		if (s % 2) x = (x * 181) >>> 8;
		return x;
	endfunction : gain
	function automatic logic [23:0] dacx(longint d, bit inv, logic [1:0] b, logic [1:0] src,
		logic [3:0] a, longint sl, sr);
		longint y;
		y = (inv ? neg(d) : d) <<< b;
		if (src == 2'h1) y += gain(sl, a);
		else if (src == 2'h2) y += gain(sr, a);
		if (y > 8388607) y = 8388607;
		if (y < -8388608) y = -8388608;
		return y[23:0];
	endfunction : dacx
	task run(input logic [15:0] rt, st, pl, input logic signed [SAMPLE_W-1:0] a, b, c, d, e, f);
		longint il, ir, sl, sr;
		wr(8'h60, rt);
		wr(8'h80, st);
		wr(8'h98, pl);
		il = pl[1] ? neg(a) : a;
		ir = pl[0] ? neg(b) : b;
		sl = pl[1] ? neg(c) : c;
		sr = pl[0] ? neg(d) : d;
		i_far.send_mic(a, b, c, d);
		@(negedge mclk_i);
		chk(24'(tx_v), 24'h1);
		chk(txl, rt[7] ? ir[23:0] : il[23:0]);
		chk(txr, rt[6] ? ir[23:0] : il[23:0]);
		i_far.send_rx(e, f);
		@(negedge mclk_i);
		chk(24'(dac_v), 24'h1);
		chk(dl, dacx(rt[5] ? f : e, rt[12], rt[10:9], st[3:2], st[11:8], sl, sr));
		chk(dr, dacx(rt[4] ? f : e, rt[11], rt[10:9], st[1:0], st[7:4], sl, sr));
	endtask : run
	initial begin
		logic [3:0] k;
		repeat (20) @(posedge mclk_i);
		arst_n_i <= 1'b1;
		@(posedge mclk_i);
		rdc(8'h60, 24'h000050);
		rdc(8'h80, 24'h000000);
		rdc(8'h98, 24'h000000);
		wr(8'h60, 16'hffff);
		rdc(8'h60, 24'h001ef0);
		wr(8'h04, 16'hffff);
		rdc(8'h04, 24'h000000);
		for (int i = 0; i < 4; i++) begin
			run({8'h00, 2'(i), 6'h00}, 16'h0, 16'(i), 24'h123456, 24'h800000, 24'h0, 24'h0, 24'h0, 24'h0);
		end
		for (int i = 0; i < 16; i++) begin
			k = 4'(i);
			run({3'h0, k[1:0], k[3:2], 1'b0, 2'b01, k[1:0] ^ k[3:2], 4'h0}, 16'h0, 16'h0,
				24'h0, 24'h0, 24'h0, 24'h0, 24'h0f1234, 24'hf5f5f6);
		end
		for (int i = 0; i < 16; i++) begin
			k = 4'(i);
			run(16'h0050, {4'h0, k, ~k, k[1:0], ~k[1:0]}, {14'h0, k[1:0]},
				24'h0, 24'h0, 24'h345678, 24'hc00000, 24'h001000, 24'hfff000);
		end
		// Left DAC invert alone, then full boost to the rail
		run(16'h1050, 16'h0, 16'h0, 24'h0, 24'h0, 24'h0, 24'h0, 24'h123456, 24'h0);
		run(16'h0650, 16'h0, 16'h0, 24'h0, 24'h0, 24'h0, 24'h0, 24'h7fffff, 24'h0);
		// Unity sidetone from the left mic filter on a silent receive sample
		run(16'h0050, 16'h0c04, 16'h0, 24'h0, 24'h0, 24'h000123, 24'h0, 24'h0, 24'h0);
		// Overdriven on purpose to reach both rails
		run(16'h0250, 16'h0cc6, 16'h0, 24'h0, 24'h0, 24'h600000, 24'ha00000, 24'h300000, 24'hd00000);
		rdc(8'h9c, 24'h000003);
		wr(8'h9c, 16'h0003);
		rdc(8'h9c, 24'h000000);
		tally_and_finish();
	end
endmodule : dam_mixer_tb
`default_nettype wire
